// ==== hw/gcs_pkg.sv ====
// Constants shared by the cycle-steal transfer block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package gcs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int CNT_W = 16;
	localparam int MEM_AW = 6;
	localparam int SYNC_W = 15;

	// Register byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_COUNT = 5'h04;
	localparam logic [4:0] REG_MADDR = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0c;
	localparam logic [4:0] REG_IN_BYTE = 5'h10;
	localparam logic [4:0] REG_OUT_BYTE = 5'h14;
	localparam logic [4:0] REG_MEM_PTR = 5'h18;
	localparam logic [4:0] REG_MEM_DATA = 5'h1c;

	// Control fields
	localparam int CTRL_W = 5;
	localparam int CTRL_DMA_EN = 0;
	localparam int CTRL_TALK_DIR = 1;
	localparam int CTRL_LISTEN = 2;
	localparam int CTRL_TALK = 3;
	localparam int CTRL_FEOI = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;

	// Status fields
	localparam int ST_COUNT_ZERO = 0;
	localparam int ST_BYTE_IN = 1;
	localparam int ST_END = 2;
	localparam int ST_BUS_REQ = 3;
	localparam int ST_ADDRESSED = 4;
	localparam int ST_OUT_FULL = 5;

	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [5:0] MADDR_RST = 6'h00;
	localparam logic [5:0] MADDR_ONE = 6'h01;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Positions within the synchronised pin vector
	localparam int SY_E = 14;
	localparam int SY_Q = 13;
	localparam int SY_BA = 12;
	localparam int SY_BS = 11;
	localparam int SY_EOI = 10;
	localparam int SY_DAV = 9;
	localparam int SY_NDAC = 8;

	typedef enum logic [1:0] {DMA_IDLE, DMA_PRE_DEAD, DMA_XFER, DMA_POST_DEAD} gcs_dma_state_type;
	typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_DONE} gcs_bus_phase_type;
endpackage : gcs_pkg

// ==== hw/gcs_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/10ps
module gcs_sync #(
	parameter int WIDTH = 15
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] sync
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta;
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					meta <= 1'b1;
					sync[i] <= 1'b1;
				end
				else
				begin
					meta <= pin[i];
					sync[i] <= meta;
				end
			end
		end
	endgenerate
endmodule : gcs_sync

// ==== hw/gcs_byte_mem.sv ====
// Block buffer for transferred bytes, one write and one registered read port.
// Assumes the caller arbitrates between engine and software.
`timescale 1ns/10ps
module gcs_byte_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [gcs_pkg::MEM_AW-1:0] waddr,
	input wire logic [gcs_pkg::BYTE_W-1:0] wdata,
	input wire logic [gcs_pkg::MEM_AW-1:0] raddr,
	output logic [gcs_pkg::BYTE_W-1:0] rdata
);
	logic [gcs_pkg::BYTE_W-1:0] store [0:(1<<gcs_pkg::MEM_AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
			store[waddr] <= wdata;
		rdata <= store[raddr];
	end
endmodule : gcs_byte_mem

// ==== hw/gcs_dma_top.sv ====
// Cycle-steal transfer control: adapter request, controller, request
// synchroniser, dead-cycle handover and Avalon-MM register slave.
// Assumes processor clocks, bus status and instrument lines arrive as pins.
//
// How it works
// R01 - Listener byte arrival raises adapter transfer request
// R02 - Bus request aligned to Q, shown while high
// R03 - Processor halts after current E cycle
// R04 - Processor floats bus, drives BA, BS high
// R05 - Controller grant is bus available AND status
// R06 - Adapter grant high during transfer E pulse
// R07 - Requests drop after move; one post dead cycle
// R08 - Each transfer spans exactly three E pulses
// R09 - Asserted end-or-identify blocks listener bus request
// R10 - Software moves last byte, disables controller
// R11 - Software enables controller on listener active
// R12 - Listener count loaded above expected length
// R13 - Talker count loaded with length minus one
// R14 - Forced end bit drives end-or-identify low
// R15 - Talker request on entry and each acceptance
// R16 - Controller interrupt only when count reaches zero
// R17 - Software traps E2 or sends last byte
// R18 - No adapter pending status means trap E3
// R19 - Addressed flag clear: disable controller, monitor
// R20 - Role flip mid-block traps E1, restart
// R21 - End status: disable controller, poll byte-in
// R22 - Remote talker releases end-or-identify after byte
// R23 - Sync flop captures on Q rise, transparent high
// R24 - Dead cycles disable all peripheral chip selects
// R25 - Bus request held off after reset
`timescale 1ns/10ps
module gcs_dma_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [gcs_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [gcs_pkg::DATA_W-1:0] avs_writedata,
	output logic [gcs_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic e_clock,
	input wire logic q_clock,
	input wire logic bus_available,
	input wire logic bus_state_out,
	input wire logic eoi_n_in,
	output logic eoi_n_out,
	output logic eoi_oe_n,
	input wire logic dav_n_in,
	input wire logic ndac_n_in,
	input wire logic [gcs_pkg::BYTE_W-1:0] ib_data_in,
	output logic [gcs_pkg::BYTE_W-1:0] ib_data_out,
	output logic ib_data_oe_n,
	output logic dav_n_out,
	output logic ib_ready,
	output logic processor_bus_request_n,
	output logic dma_grant,
	output logic dead_cycle_select_gate_n,
	output logic dma_irq
);
	logic [gcs_pkg::SYNC_W-1:0] pin_sync;
	logic e_prev;
	logic q_prev;
	logic dav_prev;
	logic ndac_prev;
	logic talk_prev;
	logic e_rise;
	logic q_rise;
	logic dav_fall;
	logic ndac_rise;
	logic talk_rise;
	logic grant_in;
	logic eoi_active;

	logic [gcs_pkg::CTRL_W-1:0] ctrl;
	logic [gcs_pkg::CNT_W-1:0] count;
	logic [gcs_pkg::MEM_AW-1:0] dma_addr;
	logic [gcs_pkg::MEM_AW-1:0] mem_ptr;
	logic count_zero;
	logic byte_in_status;
	logic end_status;
	logic out_full;
	logic adapter_req;
	logic [gcs_pkg::BYTE_W-1:0] in_byte;
	logic [gcs_pkg::BYTE_W-1:0] out_byte;
	logic req_hold;

	gcs_pkg::gcs_dma_state_type state;
	gcs_pkg::gcs_dma_state_type next_state;
	gcs_pkg::gcs_bus_phase_type phase;

	logic wr_commit;
	logic rd_commit;
	logic [gcs_pkg::ADDR_W-1:0] reg_addr;
	logic move_done;
	logic controller_transfer_request;
	logic gated_request;
	logic next_bus_request;
	logic accept_done;
	logic mem_we;
	logic [gcs_pkg::MEM_AW-1:0] mem_waddr;
	logic [gcs_pkg::BYTE_W-1:0] mem_wdata;
	logic [gcs_pkg::MEM_AW-1:0] mem_raddr;
	logic [gcs_pkg::BYTE_W-1:0] mem_rdata;
	logic [gcs_pkg::DATA_W-1:0] read_mux;
	logic [gcs_pkg::DATA_W-1:0] status_word;

	gcs_sync #(
		.WIDTH(gcs_pkg::SYNC_W)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pin({e_clock, q_clock, bus_available, bus_state_out, eoi_n_in, dav_n_in, ndac_n_in, ib_data_in}),
		.sync(pin_sync)
	);

	gcs_byte_mem u_mem (
		.clk(clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Edge detection on synchronised pins and on the talk control bit
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			e_prev <= 1'b1;
			q_prev <= 1'b1;
			dav_prev <= 1'b1;
			ndac_prev <= 1'b1;
			talk_prev <= 1'b0;
		end
		else
		begin
			e_prev <= pin_sync[gcs_pkg::SY_E];
			q_prev <= pin_sync[gcs_pkg::SY_Q];
			dav_prev <= pin_sync[gcs_pkg::SY_DAV];
			ndac_prev <= pin_sync[gcs_pkg::SY_NDAC];
			talk_prev <= ctrl[gcs_pkg::CTRL_TALK];
		end
	end

	assign e_rise = pin_sync[gcs_pkg::SY_E] & ~e_prev;
	assign q_rise = pin_sync[gcs_pkg::SY_Q] & ~q_prev;
	assign dav_fall = ~pin_sync[gcs_pkg::SY_DAV] & dav_prev;
	assign ndac_rise = pin_sync[gcs_pkg::SY_NDAC] & ~ndac_prev;
	assign talk_rise = ctrl[gcs_pkg::CTRL_TALK] & ~talk_prev;
	assign grant_in = pin_sync[gcs_pkg::SY_BA] & pin_sync[gcs_pkg::SY_BS]; // R05 R04
	assign eoi_active = ~pin_sync[gcs_pkg::SY_EOI];

	// Avalon access: request, fetch, answer with waitrequest low
	assign reg_addr = {avs_address[gcs_pkg::ADDR_W-1:2], 2'b00};
	assign wr_commit = avs_write & (phase == gcs_pkg::BUS_DONE);
	assign rd_commit = avs_read & (phase == gcs_pkg::BUS_DONE);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase <= gcs_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= gcs_pkg::READ_ZERO;
		end
		else
		begin
			case (phase)
				gcs_pkg::BUS_IDLE:
				begin
					if (avs_read | avs_write)
						phase <= gcs_pkg::BUS_FETCH;
				end
				gcs_pkg::BUS_FETCH:
				begin
					phase <= gcs_pkg::BUS_DONE;
					avs_waitrequest <= 1'b0;
					avs_readdata <= avs_read ? read_mux : gcs_pkg::READ_ZERO;
				end
				default:
				begin
					phase <= gcs_pkg::BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	assign status_word = {26'h0, out_full, ctrl[gcs_pkg::CTRL_LISTEN] | ctrl[gcs_pkg::CTRL_TALK],
		~processor_bus_request_n, end_status, byte_in_status, count_zero};

	always_comb
	begin
		case (reg_addr)
			gcs_pkg::REG_CTRL: read_mux = {27'h0, ctrl};
			gcs_pkg::REG_COUNT: read_mux = {16'h0, count};
			gcs_pkg::REG_MADDR: read_mux = {26'h0, dma_addr};
			gcs_pkg::REG_STATUS: read_mux = status_word;
			gcs_pkg::REG_IN_BYTE: read_mux = {24'h0, in_byte};
			gcs_pkg::REG_OUT_BYTE: read_mux = {24'h0, out_byte};
			gcs_pkg::REG_MEM_PTR: read_mux = {26'h0, mem_ptr};
			gcs_pkg::REG_MEM_DATA: read_mux = {24'h0, mem_rdata};
			default: read_mux = gcs_pkg::READ_ZERO;
		endcase
	end

	// Handover sequence stepped on E rising edges
	assign move_done = e_rise & (state == gcs_pkg::DMA_XFER);

	always_comb
	begin
		next_state = state;
		case (state)
			gcs_pkg::DMA_IDLE:
			begin
				if (e_rise & ~processor_bus_request_n & grant_in) // R03
					next_state = gcs_pkg::DMA_PRE_DEAD;
			end
			gcs_pkg::DMA_PRE_DEAD:
			begin
				if (e_rise)
					next_state = gcs_pkg::DMA_XFER; // R08
			end
			gcs_pkg::DMA_XFER:
			begin
				if (e_rise)
					next_state = gcs_pkg::DMA_POST_DEAD; // R07
			end
			default:
			begin
				if (e_rise)
					next_state = gcs_pkg::DMA_IDLE; // R07 R08
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= gcs_pkg::DMA_IDLE;
			dma_grant <= 1'b0;
			dead_cycle_select_gate_n <= 1'b1;
		end
		else
		begin
			state <= next_state;
			dma_grant <= next_state == gcs_pkg::DMA_XFER; // R06
			dead_cycle_select_gate_n <= ~((next_state == gcs_pkg::DMA_PRE_DEAD) |
				(next_state == gcs_pkg::DMA_POST_DEAD)); // R24
		end
	end

	// Request synchroniser
	assign controller_transfer_request = ctrl[gcs_pkg::CTRL_DMA_EN] & adapter_req & ~count_zero &
		(state != gcs_pkg::DMA_POST_DEAD);
	assign gated_request = controller_transfer_request & (ctrl[gcs_pkg::CTRL_TALK_DIR] | ~eoi_active); // R09
	assign next_bus_request = pin_sync[gcs_pkg::SY_Q] ? gated_request : req_hold; // R02 R23

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_hold <= 1'b0; // R25
			processor_bus_request_n <= 1'b1; // R25
		end
		else
		begin
			if (q_rise | pin_sync[gcs_pkg::SY_Q])
				req_hold <= gated_request; // R23
			processor_bus_request_n <= ~next_bus_request; // R02
		end
	end

	// Control register; forced end clears once its byte is accepted
	assign accept_done = out_full & ndac_rise;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ctrl <= gcs_pkg::CTRL_RST;
		else
		begin
			if (accept_done)
				ctrl[gcs_pkg::CTRL_FEOI] <= 1'b0;
			if (wr_commit & (reg_addr == gcs_pkg::REG_CTRL))
				ctrl <= avs_writedata[gcs_pkg::CTRL_W-1:0];
		end
	end

	// Byte counter, address and zero-count interrupt
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count <= gcs_pkg::COUNT_RST;
			dma_addr <= gcs_pkg::MADDR_RST;
			count_zero <= 1'b0;
			dma_irq <= 1'b0;
		end
		else
		begin
			if (wr_commit & (reg_addr == gcs_pkg::REG_COUNT))
				count <= avs_writedata[gcs_pkg::CNT_W-1:0];
			if (wr_commit & (reg_addr == gcs_pkg::REG_MADDR))
				dma_addr <= avs_writedata[gcs_pkg::MEM_AW-1:0];
			if (wr_commit & (reg_addr == gcs_pkg::REG_STATUS) & avs_writedata[gcs_pkg::ST_COUNT_ZERO])
				count_zero <= 1'b0;
			if (move_done)
			begin
				count <= count - gcs_pkg::COUNT_ONE;
				dma_addr <= dma_addr + gcs_pkg::MADDR_ONE;
				if (count == gcs_pkg::COUNT_ONE)
					count_zero <= 1'b1; // R16
			end
			dma_irq <= count_zero; // R16
		end
	end

	// Adapter transfer request
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			adapter_req <= 1'b0;
		else
		begin
			if (move_done)
				adapter_req <= 1'b0; // R07
			if (dav_fall & ctrl[gcs_pkg::CTRL_LISTEN])
				adapter_req <= 1'b1; // R01
			if (talk_rise | (accept_done & ctrl[gcs_pkg::CTRL_TALK]))
				adapter_req <= 1'b1; // R15
		end
	end

	// Listener side: byte capture, byte-in and end status
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			in_byte <= gcs_pkg::BYTE_RST;
			byte_in_status <= 1'b0;
			end_status <= 1'b0;
			ib_ready <= 1'b0;
		end
		else
		begin
			if ((rd_commit & (reg_addr == gcs_pkg::REG_IN_BYTE)) | (move_done & ~ctrl[gcs_pkg::CTRL_TALK_DIR]))
				byte_in_status <= 1'b0;
			if (dav_fall & ctrl[gcs_pkg::CTRL_LISTEN])
			begin
				in_byte <= pin_sync[gcs_pkg::BYTE_W-1:0]; // R01
				byte_in_status <= 1'b1;
			end
			if (wr_commit & (reg_addr == gcs_pkg::REG_STATUS) & avs_writedata[gcs_pkg::ST_END])
				end_status <= 1'b0;
			if (eoi_active & ctrl[gcs_pkg::CTRL_LISTEN])
				end_status <= 1'b1;
			ib_ready <= ctrl[gcs_pkg::CTRL_LISTEN] & ~byte_in_status;
		end
	end

	// Talker side: output buffer, data valid and forced end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_byte <= gcs_pkg::BYTE_RST;
			out_full <= 1'b0;
			dav_n_out <= 1'b1;
			ib_data_out <= gcs_pkg::BYTE_RST;
			ib_data_oe_n <= 1'b1;
			eoi_n_out <= 1'b1;
			eoi_oe_n <= 1'b1;
		end
		else
		begin
			if (accept_done)
				out_full <= 1'b0; // R15
			if (wr_commit & (reg_addr == gcs_pkg::REG_OUT_BYTE))
			begin
				out_byte <= avs_writedata[gcs_pkg::BYTE_W-1:0];
				out_full <= 1'b1;
			end
			else if (move_done & ctrl[gcs_pkg::CTRL_TALK_DIR])
			begin
				out_byte <= mem_rdata;
				out_full <= 1'b1;
			end
			dav_n_out <= ~(out_full & ctrl[gcs_pkg::CTRL_TALK]);
			ib_data_out <= out_byte;
			ib_data_oe_n <= ~ctrl[gcs_pkg::CTRL_TALK];
			eoi_n_out <= ~ctrl[gcs_pkg::CTRL_FEOI]; // R14
			eoi_oe_n <= ~ctrl[gcs_pkg::CTRL_FEOI]; // R14
		end
	end

	// Software memory pointer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			mem_ptr <= gcs_pkg::MADDR_RST;
		else if (wr_commit & (reg_addr == gcs_pkg::REG_MEM_PTR))
			mem_ptr <= avs_writedata[gcs_pkg::MEM_AW-1:0];
	end

	// Engine owns the read port while a transfer is in progress; its listener write wins over software in the move cycle
	always_comb
	begin
		mem_we = 1'b0;
		mem_waddr = mem_ptr;
		mem_wdata = avs_writedata[gcs_pkg::BYTE_W-1:0];
		mem_raddr = (state == gcs_pkg::DMA_IDLE) ? mem_ptr : dma_addr;
		if (move_done & ~ctrl[gcs_pkg::CTRL_TALK_DIR])
		begin
			mem_we = 1'b1;
			mem_waddr = dma_addr;
			mem_wdata = in_byte;
		end
		else if (wr_commit & (reg_addr == gcs_pkg::REG_MEM_DATA))
			mem_we = 1'b1;
	end
endmodule : gcs_dma_top

// ==== verif/gcs_dma_props.sv ====
// Port assertions for the cycle-steal transfer block.
// Assumes E and Q each span eight clk cycles, as the processor model makes them.
`timescale 1ns/10ps
module gcs_dma_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic q_clock,
	input wire logic bus_available,
	input wire logic bus_state_out,
	input wire logic eoi_n_in,
	input wire logic eoi_n_out,
	input wire logic eoi_oe_n,
	input wire logic dav_n_in,
	input wire logic ib_data_oe_n,
	input wire logic ib_ready,
	input wire logic processor_bus_request_n,
	input wire logic dma_grant,
	input wire logic dead_cycle_select_gate_n,
	input wire logic dma_irq
);
	default clocking cb @(posedge clk);
	endclocking
	// Reset already seen at an earlier edge, so the outputs have had time to clear
	logic rst_seen;
	always_ff @(posedge clk)
		rst_seen <= !reset_n;
	default disable iff (!reset_n);
	sequence s_dead;
		(!dead_cycle_select_gate_n && !dma_grant) [*8];
	endsequence
	sequence s_move;
		(dead_cycle_select_gate_n && dma_grant) [*8];
	endsequence
	a_three_pulses: assert property ($fell(dead_cycle_select_gate_n) && !$past(dma_grant) |->
		s_dead ##1 s_move ##1 s_dead ##1 dead_cycle_select_gate_n)
		else $error("transfer phases out of order");
	a_req_in_q: assert property ($fell(processor_bus_request_n) |->
		$past(q_clock, 2) || $past(q_clock, 3) || $past(q_clock, 4))
		else $error("bus request outside Q high");
	a_eoi_blocks: assert property (ib_data_oe_n && !eoi_n_in && !$past(eoi_n_in, 4) |->
		!$fell(processor_bus_request_n))
		else $error("bus request while end line low");
	a_byte_req: assert property ($fell(dav_n_in) && ib_ready && eoi_n_in |->
		##[3:20] !processor_bus_request_n)
		else $error("received byte raised no bus request");
	a_grant_bus: assert property ($rose(dma_grant) |-> bus_available && bus_state_out)
		else $error("grant without bus handed over");
	a_req_drop: assert property ($fell(dma_grant) |-> ##[1:14] processor_bus_request_n)
		else $error("bus request kept after move");
	a_irq_zero: assert property ($rose(dma_irq) |-> $past(dma_grant, 2) || $past(dma_grant, 3))
		else $error("interrupt without final move");
	a_feoi_drive: assert property (!eoi_oe_n |-> !eoi_n_out)
		else $error("end line enabled but not low");
	a_reset_quiet: assert property (disable iff (1'b0) !reset_n && rst_seen |->
		processor_bus_request_n && dead_cycle_select_gate_n && !dma_grant)
		else $error("bus outputs active in reset");
endmodule : gcs_dma_props
bind gcs_dma_top gcs_dma_props u_props (.clk(clk), .reset_n(reset_n), .q_clock(q_clock),
	.bus_available(bus_available), .bus_state_out(bus_state_out), .eoi_n_in(eoi_n_in),
	.eoi_n_out(eoi_n_out), .eoi_oe_n(eoi_oe_n), .dav_n_in(dav_n_in), .ib_data_oe_n(ib_data_oe_n),
	.ib_ready(ib_ready), .processor_bus_request_n(processor_bus_request_n), .dma_grant(dma_grant),
	.dead_cycle_select_gate_n(dead_cycle_select_gate_n), .dma_irq(dma_irq));

// ==== verif/gcs_proc_model.sv ====
// Processor model: E and Q clocks and the bus handover outputs.
// Assumes eight clk cycles per E period, Q leading E by a quarter.
`timescale 1ns/10ps
module gcs_proc_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic processor_bus_request_n,
	output logic e_clock,
	output logic q_clock,
	output logic bus_available,
	output logic bus_state_out
);
	logic [2:0] phase;
	logic halted;
	logic halted_d;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase <= 3'h0;
			halted <= 1'b0;
			halted_d <= 1'b0;
		end
		else
		begin
			phase <= phase + 3'h1;
			// Halt only decided as the current E cycle ends
			if (phase == 3'h7)
			begin
				halted <= !processor_bus_request_n;
				halted_d <= halted;
			end
		end
	end
	assign e_clock = phase[2];
	assign q_clock = (phase >= 3'h2) && (phase <= 3'h5);
	assign bus_available = halted || halted_d;
	assign bus_state_out = halted || halted_d;
endmodule : gcs_proc_model

// ==== verif/gcs_dma_top_tb.sv ====
// Self-checking bench for the cycle-steal transfer block.
// Assumes the processor model supplies E, Q and bus status pins.
`timescale 1ns/10ps
module gcs_dma_top_tb;
	logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic e_clock, q_clock, bus_available, bus_state_out;
	logic eoi_n_in, eoi_n_out, eoi_oe_n, dav_n_in, ndac_n_in, dav_n_out, ib_ready;
	logic [7:0] ib_data_in, ib_data_out, tb_data;
	logic ib_data_oe_n, processor_bus_request_n, dma_grant, dead_cycle_select_gate_n, dma_irq;
	logic tb_dav_n, tb_eoi_n, grant_d;
	int failures = 0;
	int samples_checked = 0;
	int grants = 0;
	int g0;
	logic [7:0] lb [2] = '{8'ha5, 8'h3c};
	logic [7:0] tk [2] = '{8'hc3, 8'h96};
	// Shared lines resolved from every party's drive
	assign dav_n_in = tb_dav_n & dav_n_out;
	assign eoi_n_in = tb_eoi_n & (eoi_oe_n | eoi_n_out);
	assign ib_data_in = ib_data_oe_n ? tb_data : ib_data_out;
	gcs_dma_top DUT (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .e_clock(e_clock), .q_clock(q_clock),
		.bus_available(bus_available), .bus_state_out(bus_state_out), .eoi_n_in(eoi_n_in),
		.eoi_n_out(eoi_n_out), .eoi_oe_n(eoi_oe_n), .dav_n_in(dav_n_in), .ndac_n_in(ndac_n_in),
		.ib_data_in(ib_data_in), .ib_data_out(ib_data_out), .ib_data_oe_n(ib_data_oe_n),
		.dav_n_out(dav_n_out), .ib_ready(ib_ready), .processor_bus_request_n(processor_bus_request_n),
		.dma_grant(dma_grant), .dead_cycle_select_gate_n(dead_cycle_select_gate_n), .dma_irq(dma_irq));
	gcs_proc_model u_proc (.clk(clk), .reset_n(reset_n), .processor_bus_request_n(processor_bus_request_n),
		.e_clock(e_clock), .q_clock(q_clock), .bus_available(bus_available), .bus_state_out(bus_state_out));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		grant_d <= dma_grant;
		if (dma_grant && !grant_d)
			grants <= grants + 1;
	end
	task automatic print_verdict;
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input string s, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(s, e, q);
	endtask : rd
	task automatic till(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		if (s !== v)
			chk("wait", {31'h0, v}, {31'h0, s});
	endtask : till
	task automatic accept;
		ndac_n_in <= 1'b1;
		repeat (6) @(posedge clk);
		ndac_n_in <= 1'b0;
		@(posedge clk);
	endtask : accept
	initial
	begin
		reset_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{tb_dav_n, tb_eoi_n, ndac_n_in, tb_data} = {1'b1, 1'b1, 1'b0, 8'h00};
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("breq", 32'h1, {31'h0, processor_bus_request_n});
		rd("ctrl", gcs_pkg::REG_CTRL, 32'h0);
		wr(gcs_pkg::REG_MADDR, 32'h0);
		wr(gcs_pkg::REG_COUNT, 32'h10);
		wr(gcs_pkg::REG_CTRL, 32'h5);
		foreach (lb[i])
		begin
			tb_data <= lb[i];
			tb_dav_n <= 1'b0;
			repeat (6) @(posedge clk);
			tb_dav_n <= 1'b1;
			till(dma_grant, 1'b1);
			till(dma_grant, 1'b0);
		end
		repeat (30) @(posedge clk);
		rd("count", gcs_pkg::REG_COUNT, 32'he);
		wr(gcs_pkg::REG_MEM_PTR, 32'h1);
		rd("mem", gcs_pkg::REG_MEM_DATA, {24'h0, lb[1]});
		tb_eoi_n <= 1'b0;
		repeat (8) @(posedge clk);
		g0 = grants;
		tb_data <= 8'h5a;
		tb_dav_n <= 1'b0;
		repeat (6) @(posedge clk);
		tb_dav_n <= 1'b1;
		repeat (100) @(posedge clk);
		chk("grants", g0, grants);
		rd("status", gcs_pkg::REG_STATUS, 32'h16);
		rd("last", gcs_pkg::REG_IN_BYTE, 32'h5a);
		wr(gcs_pkg::REG_CTRL, 32'h0);
		tb_eoi_n <= 1'b1;
		rd("unaddr", gcs_pkg::REG_STATUS, 32'h4);
		wr(gcs_pkg::REG_MEM_PTR, 32'h4);
		wr(gcs_pkg::REG_MEM_DATA, {24'h0, tk[0]});
		wr(gcs_pkg::REG_MEM_PTR, 32'h5);
		wr(gcs_pkg::REG_MEM_DATA, {24'h0, tk[1]});
		wr(gcs_pkg::REG_MADDR, 32'h4);
		wr(gcs_pkg::REG_COUNT, 32'h2);
		wr(gcs_pkg::REG_CTRL, 32'hb);
		foreach (tk[i])
		begin
			till(dav_n_out, 1'b0);
			chk("out", {24'h0, tk[i]}, {24'h0, ib_data_out});
			if (i == 0)
				chk("irq", 32'h0, {31'h0, dma_irq});
			accept();
		end
		till(dma_irq, 1'b1);
		chk("irq", 32'h1, {31'h0, dma_irq});
		rd("dir", gcs_pkg::REG_CTRL, 32'hb);
		wr(gcs_pkg::REG_CTRL, 32'h1a);
		repeat (3) @(posedge clk);
		chk("eoi", 32'h0, {30'h0, eoi_oe_n, eoi_n_out});
		wr(gcs_pkg::REG_OUT_BYTE, 32'h77);
		till(dav_n_out, 1'b0);
		chk("last out", 32'h77, {24'h0, ib_data_out});
		accept();
		repeat (10) @(posedge clk);
		chk("eoi off", 32'h1, {31'h0, eoi_oe_n});
		wr(gcs_pkg::REG_STATUS, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq clr", 32'h0, {31'h0, dma_irq});
		print_verdict();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule : gcs_dma_top_tb
